// ===== logic/wswc_top.sv
// Watchdog timer, time-out and power-down flags and sleep entry and exit control.
// Assumes one always-running 25 MHz clock, a core that pulses its sleep and kick
// instructions for one cycle, and an AHB-Lite master for the registers.
//
// Local design decision: register access over AHB-Lite.
`timescale 1ns/1ps
`include "wswc_map.svh"

module wswc_top #(
   parameter int unsigned WDT_TICKS = (`WSWC_WDT_PERIOD_US * 1000) / `WSWC_OSC_TICK_NS,
   parameter int unsigned WDT_W     = 15,
   parameter int unsigned TICK_CYC  = `WSWC_OSC_TICK_NS / `WSWC_CLK_PERIOD_NS
) (
   input  wire logic        sys_clk,              // Always-running block clock.
   input  wire logic        rst,                  // Power-on reset, async, high.
   input  wire logic        hsel,                 // AHB slave select.
   input  wire logic [31:0] haddr,                // AHB byte address.
   input  wire logic [1:0]  htrans,               // AHB transfer type.
   input  wire logic        hwrite,               // AHB write strobe.
   input  wire logic [2:0]  hsize,                // AHB size, word only.
   input  wire logic [31:0] hwdata,               // AHB write data.
   input  wire logic        hready,               // AHB bus ready.
   output logic             hreadyout,            // Slave never stalls.
   output logic [31:0]      hrdata,               // Registered read data.
   output logic             hresp,                // Always OKAY.
   input  wire logic [7:0]  config_word_in,       // Fuse word, caught after reset.
   input  wire logic        master_clear_n,       // External master clear pin.
   input  wire logic        sleep_instr,          // Core executes sleep.
   input  wire logic        kick_watchdog_instr,  // Core executes watchdog clear.
   input  wire logic [2:0]  wake_irq_flags,       // Pin, port change, EEPROM flags.
   input  wire logic [2:0]  wake_irq_enables,     // Their individual enables.
   input  wire logic        timer_irq_flag,       // Phase-clocked timer flag.
   input  wire logic        timer_irq_enable,     // Its individual enable.
   input  wire logic        global_irq_enable,    // Core global enable.
   output logic             internal_reset,       // Device reset to the core.
   output logic             main_osc_en,          // Main oscillator driver on.
   output logic             io_hold,              // Freeze all pin drivers.
   output logic             prefetch_next,        // Fetch the next address now.
   output logic             sleep_nop,            // Sleep completed as no-op.
   output logic             wake_pulse,           // Resume execution after sleep.
   output logic             vector_branch,        // Branch to interrupt vector.
   output logic             timeout_flag_n,       // Active-low time-out flag.
   output logic             powerdown_flag_n      // Active-low power-down flag.
);

   // ****************************************************************
   // Declarations.
   // ****************************************************************
   wswc_pkg::wswc_state_e state, next_state;      // Power state.
   logic [4:0]            tick_div, next_tick_div; // Oscillator tick divider.
   logic                  osc_tick;                // One-cycle oscillator tick.
   logic [6:0]            pre_cnt, next_pre_cnt;   // Watchdog prescaler.
   logic [WDT_W-1:0]      wdt_cnt, next_wdt_cnt;   // Watchdog count.
   logic                  wdt_step;                // Prescaled tick.
   logic                  wdt_timeout;             // Terminal count reached.
   logic                  next_timeout_n, next_powerdown_n;
   logic                  wdt_rst_q, next_wdt_rst; // Watchdog reset pulse.
   logic                  next_wake, next_vector, next_prefetch, next_nop;
   logic                  irq_pending;             // Any enabled flag, awake.
   logic                  wake_irq;                // Sleep-capable enabled flag.
   logic                  sleep_go;                // Sleep really entered.
   logic                  wdt_clear;               // Count and prescaler clear.
   logic [7:0]            option, next_option;     // Timer prescaler options.
   logic [7:0]            cfg, next_cfg;           // Captured fuse word.
   logic                  cfg_done, next_cfg_done; // Fuse word has been caught.
   logic                  wr_pend, next_wr_pend;   // Option write in data phase.
   logic [31:0]           next_hrdata;
   logic                  master_clear_n_low;                // Master clear asserted.
   logic                  fuse_en;                 // Watchdog fuse enable.

   assign master_clear_n_low = !master_clear_n;
   assign fuse_en  = cfg[`WSWC_CFG_WATCHDOG_FUSE_ENABLE_BIT];

   // ****************************************************************
   // Address decode, shared by the read and write paths.
   // ****************************************************************
   // Returns 1 for option, 2 for config, 3 for status, 0 for unmapped.
   function automatic logic [1:0] reg_sel(input logic [31:0] addr);
      logic [1:0] sel;
      sel = 2'h0;
      if (addr == 32'(`WSWC_IDX_OPTION * 4)) begin
         sel = 2'h1;
      end else if (addr == 32'(`WSWC_IDX_CONFIG * 4)) begin
         sel = 2'h2;
      end else if (addr == 32'(`WSWC_IDX_STATUS * 4)) begin
         sel = 2'h3;
      end
      return sel;
   endfunction : reg_sel

   // ****************************************************************
   // Watchdog oscillator and counter.
   // ****************************************************************
   // The tick comes from a divider of the always-on clock, never from the main
   // oscillator, so the count continues while sleep has that oscillator off.
   assign osc_tick = (tick_div == 5'(TICK_CYC - 1));

   // Prescaled step: ratio 2^ps when the prescaler belongs to the watchdog.
   always_comb begin
      logic [6:0] mask;
      mask = 7'h00;
      for (int i = 0; i < 7; i++) begin
         mask[i] = (3'(i) < option[`WSWC_OPT_PS_MSB:0]);
      end
      if (option[`WSWC_OPT_PSA_BIT]) begin
         wdt_step = osc_tick && ((pre_cnt & mask) == mask);
      end else begin
         wdt_step = osc_tick;
      end
   end

   // Expiry is impossible with the fuse off, whatever the count does.
   assign wdt_timeout = fuse_en && wdt_step &&
                        (wdt_cnt == WDT_W'(WDT_TICKS - 1));

   // Enabled pending interrupts: the timer source only counts while awake.
   assign wake_irq    = |(wake_irq_flags & wake_irq_enables);
   assign irq_pending = wake_irq || (timer_irq_flag && timer_irq_enable);
   assign sleep_go    = sleep_instr && (state == wswc_pkg::WSWC_RUN) &&
                        !irq_pending && !master_clear_n_low;
   assign wdt_clear   = kick_watchdog_instr || sleep_go || master_clear_n_low;

   // Next count: clear wins over a step; expiry restarts from zero.
   always_comb begin
      next_tick_div = osc_tick ? 5'h00 : tick_div + 5'h01;
      next_pre_cnt  = pre_cnt;
      next_wdt_cnt  = wdt_cnt;
      if (wdt_clear) begin
         next_pre_cnt = 7'h00;
         next_wdt_cnt = '0;
      end else if (osc_tick) begin
         next_pre_cnt = pre_cnt + 7'h01;
         if (wdt_step) begin
            next_wdt_cnt = wdt_timeout ? '0 : wdt_cnt + WDT_W'(1);
         end
      end
   end

   // Counter registers.
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         tick_div <= 5'h00;
         pre_cnt  <= 7'h00;
         wdt_cnt  <= '0;
      end else begin
         tick_div <= next_tick_div;
         pre_cnt  <= next_pre_cnt;
         wdt_cnt  <= next_wdt_cnt;
      end
   end

   // ****************************************************************
   // Power state, flags and core hand-over pulses.
   // ****************************************************************
   // The timer interrupt is left out of the wake term because its phase
   // clocks are stopped in sleep. Master clear overrides the state and the wake and vector pulses.
   always_comb begin
      next_state       = state;
      next_timeout_n   = timeout_flag_n;
      next_powerdown_n = powerdown_flag_n;
      next_wdt_rst     = 1'b0;
      next_wake        = 1'b0;
      next_vector      = 1'b0;
      next_prefetch    = sleep_go;
      next_nop         = sleep_instr && (state == wswc_pkg::WSWC_RUN) &&
                         irq_pending && !master_clear_n_low;
      unique case (state)
         wswc_pkg::WSWC_RUN: begin
            if (sleep_go) begin
               next_state       = wswc_pkg::WSWC_SLEEP;
               next_timeout_n   = 1'b1;
               next_powerdown_n = 1'b0;
            end
            if (wdt_timeout) begin
               next_wdt_rst     = 1'b1;
               next_timeout_n   = 1'b0;
               next_powerdown_n = 1'b1;
               next_state       = wswc_pkg::WSWC_RUN;
            end
         end
         wswc_pkg::WSWC_SLEEP: begin
            // An interrupt pending at the sleep entry makes it a no-op; one arriving
            // in the next cycle wakes here, one cycle after sleep finished clearing the watchdog.
            if (wdt_timeout || wake_irq) begin
               next_state  = wswc_pkg::WSWC_WAKE;
               next_wake   = 1'b1;
               next_vector = wake_irq && global_irq_enable;
            end
            if (wdt_timeout) begin
               next_timeout_n = 1'b0;
            end
         end
         wswc_pkg::WSWC_WAKE: begin
            next_state = wswc_pkg::WSWC_RUN;
            if (wdt_timeout) begin
               next_timeout_n = 1'b0;
               next_wdt_rst   = 1'b1;
            end
         end
      endcase
      if (master_clear_n_low) begin
         next_state = wswc_pkg::WSWC_RUN;
         next_wake  = 1'b0;
         next_vector = 1'b0;
      end
   end

   // State registers; power-on leaves both active-low flags set.
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         state            <= wswc_pkg::WSWC_RUN;
         timeout_flag_n   <= 1'b1;
         powerdown_flag_n <= 1'b1;
         wdt_rst_q        <= 1'b0;
         wake_pulse       <= 1'b0;
         vector_branch    <= 1'b0;
         prefetch_next    <= 1'b0;
         sleep_nop        <= 1'b0;
      end else begin
         state            <= next_state;
         timeout_flag_n   <= next_timeout_n;
         powerdown_flag_n <= next_powerdown_n;
         wdt_rst_q        <= next_wdt_rst;
         wake_pulse       <= next_wake;
         vector_branch    <= next_vector;
         prefetch_next    <= next_prefetch;
         sleep_nop        <= next_nop;
      end
   end

   // The watchdog reset is internal only; this block has no path to the pin.
   assign internal_reset = wdt_rst_q || master_clear_n_low;
   assign main_osc_en    = (state != wswc_pkg::WSWC_SLEEP);
   assign io_hold        = (state == wswc_pkg::WSWC_SLEEP);

   // ****************************************************************
   // AHB-Lite register slave.
   // ****************************************************************
   // Zero wait states. Read data are captured in the address phase; a read
   // right after an option write is bypassed from hwdata so it is not stale.
   always_comb begin
      logic       take;
      logic [1:0] sel;
      take          = hsel && htrans[1] && hready;
      sel           = reg_sel(haddr);
      next_option   = option;
      next_cfg      = cfg;
      next_cfg_done = 1'b1;
      next_wr_pend  = take && hwrite && (sel == 2'h1);
      next_hrdata   = hrdata;
      if (!cfg_done) begin
         next_cfg = config_word_in;
         next_cfg[7:`WSWC_CFG_MSB+1] = '0;
      end
      if (wr_pend) begin
         next_option = hwdata[7:0];
      end
      if (take && !hwrite) begin
         unique case (sel)
            2'h1: next_hrdata = {24'h000000, wr_pend ? hwdata[7:0] : option};
            2'h2: next_hrdata = {24'h000000, cfg};
            2'h3: next_hrdata = {27'h0000000, timeout_flag_n, powerdown_flag_n,
                                 3'h0};
            2'h0: next_hrdata = 32'h00000000;
         endcase
      end
   end

   // Bus registers; the fuse word is caught in the first cycle after release.
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         option   <= `WSWC_OPTION_RST;
         cfg      <= 8'h00;
         cfg_done <= 1'b0;
         wr_pend  <= 1'b0;
         hrdata   <= 32'h00000000;
      end else begin
         option   <= next_option;
         cfg      <= next_cfg;
         cfg_done <= next_cfg_done;
         wr_pend  <= next_wr_pend;
         hrdata   <= next_hrdata;
      end
   end

   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;

   // ****************************************************************
   // Assertions.
   // ****************************************************************
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);

   sequence s_sleep_req;
      sleep_instr && (state == wswc_pkg::WSWC_RUN) && !master_clear_n_low;
   endsequence

   sequence s_sleeping_quiet;
      (state == wswc_pkg::WSWC_SLEEP) && !wdt_timeout && !master_clear_n_low;
   endsequence

   // An expiry in the entry cycle wins over sleep, so it is left out here.
   sleep_entry_a: assert property (s_sleep_req ##0 !irq_pending && !wdt_timeout |=>
      (state == wswc_pkg::WSWC_SLEEP) && !powerdown_flag_n && timeout_flag_n &&
      !main_osc_en && (wdt_cnt == '0) && prefetch_next)
      else $error("sleep entry did not set flags and stop oscillator");

   sleep_noop_a: assert property (s_sleep_req ##0 irq_pending && !wdt_timeout |=>
      (state == wswc_pkg::WSWC_RUN) && sleep_nop &&
      (powerdown_flag_n == $past(powerdown_flag_n)) &&
      (timeout_flag_n == $past(timeout_flag_n)))
      else $error("sleep with pending interrupt changed state or flags");

   wdt_reset_a: assert property ((state == wswc_pkg::WSWC_RUN) && wdt_timeout
      |=> internal_reset && !timeout_flag_n && powerdown_flag_n ##1 !wdt_rst_q)
      else $error("watchdog expiry in run gave no one-cycle reset");

   wdt_wake_a: assert property ((state == wswc_pkg::WSWC_SLEEP) && wdt_timeout &&
      !master_clear_n_low |=> wake_pulse && !wdt_rst_q && !timeout_flag_n && !powerdown_flag_n)
      else $error("watchdog expiry in sleep did not wake cleanly");

   // Watches the outputs, not the gated term, so a bypass of the fuse is caught.
   fuse_off_a: assert property (!fuse_en |=> !wdt_rst_q && !$fell(timeout_flag_n))
      else $error("watchdog reset or time-out flag with fuse disabled");

   irq_wake_a: assert property (s_sleeping_quiet ##0 wake_irq |=>
      wake_pulse && (vector_branch == $past(global_irq_enable)) ##1
      (state == wswc_pkg::WSWC_RUN))
      else $error("enabled interrupt did not wake within one cycle");

   timer_quiet_a: assert property (s_sleeping_quiet ##0 !wake_irq |=>
      (state == wswc_pkg::WSWC_SLEEP) && io_hold)
      else $error("sleep left without a wake source");

   kick_clear_a: assert property (kick_watchdog_instr |=>
      (wdt_cnt == '0) && (pre_cnt == 7'h00))
      else $error("kick did not clear count and prescaler");

   master_clear_n_wake_a: assert property ((state == wswc_pkg::WSWC_SLEEP) && master_clear_n_low |->
      internal_reset ##1 (state == wswc_pkg::WSWC_RUN) && !wake_pulse)
      else $error("master clear in sleep did not reset");

endmodule : wswc_top

// ===== logic/wswc_map.svh
// Register offsets, field positions, reset values and timing figures of the watchdog block.
// Assumes it is included by its bare name from the bench or the design module.
`ifndef WSWC_MAP_SVH
`define WSWC_MAP_SVH

// ****************************************************************
// Register indices; the byte address is four times the index.
// ****************************************************************
`define WSWC_IDX_STATUS      16'h0003
`define WSWC_IDX_OPTION      16'h0081
`define WSWC_IDX_CONFIG      16'h2007

// ****************************************************************
// Field positions.
// ****************************************************************
`define WSWC_OPT_PSA_BIT     3
`define WSWC_OPT_PS_MSB      2
`define WSWC_ST_TO_BIT       4
`define WSWC_ST_PD_BIT       3
`define WSWC_CFG_WATCHDOG_FUSE_ENABLE_BIT    2
`define WSWC_CFG_MSB         4

// ****************************************************************
// Reset values.
// ****************************************************************
`define WSWC_OPTION_RST      8'hff

// ****************************************************************
// Timing: clock period, watchdog oscillator tick and nominal period.
// ****************************************************************
`define WSWC_CLK_PERIOD_NS   40
`define WSWC_OSC_TICK_NS     1000
`define WSWC_WDT_PERIOD_US   18000

`endif

// ===== logic/wswc_pkg.sv
// Types shared by the watchdog and sleep control block.
// Assumes nothing of its surroundings; the numbers live in the map header.
package wswc_pkg;

   // ****************************************************************
   // Power state of the device, one-hot.
   // ****************************************************************
   typedef enum logic [2:0] {
      WSWC_RUN   = 3'b001,  // Core executing normally.
      WSWC_SLEEP = 3'b010,  // Main oscillator stopped, pins held.
      WSWC_WAKE  = 3'b100   // One cycle of wake-up hand-over.
   } wswc_state_e;

   typedef logic [7:0] wswc_byte_t;  // One 8-bit register value.

endpackage : wswc_pkg

// ===== sim/wswc_core_model.sv
// Partner model of the processor core beside the watchdog and sleep block.
// Assumes the block's 25 MHz clock and one-cycle sleep and kick pulses.
`timescale 1ns/1ps
module wswc_core_model (
   input  wire logic       sys_clk,              // Block clock.
   output logic            sleep_instr,          // Sleep pulse.
   output logic            kick_watchdog_instr,  // Watchdog clear pulse.
   output logic [2:0]      wake_irq_flags,       // Pin, port change, EEPROM flags.
   output logic [2:0]      wake_irq_enables,     // Their enables.
   output logic            timer_irq_flag,       // Phase-clocked timer flag.
   output logic            timer_irq_enable,     // Its enable.
   output logic            global_irq_enable,    // Global enable.
   output logic            master_clear_n        // Master clear pin.
);
   // An idle core: no pulses, no interrupts, master clear released.
   initial begin
      {sleep_instr, kick_watchdog_instr, timer_irq_flag, timer_irq_enable} = 4'h0;
      {wake_irq_flags, wake_irq_enables, global_irq_enable} = 7'h00;
      master_clear_n = 1'b1;
   end
   // One watchdog clear, released at the edge that takes it.
   task automatic kick();
      @(posedge sys_clk);
      kick_watchdog_instr <= 1'b1;
      @(posedge sys_clk);
      kick_watchdog_instr <= 1'b0;
   endtask : kick
   // Clear first, then sleep back to back, so the count starts known.
   task automatic do_sleep();
      kick();
      sleep_instr <= 1'b1;
      @(posedge sys_clk);
      sleep_instr <= 1'b0;
   endtask : do_sleep
   // Sets all interrupt levels, the global enable and the pin at one edge.
   task automatic drive(input logic [2:0] f, input logic [2:0] e, input logic [1:0] t,
                        input logic g, input logic m);
      @(posedge sys_clk);
      wake_irq_flags <= f;
      wake_irq_enables <= e;
      {timer_irq_flag, timer_irq_enable} <= t;
      global_irq_enable <= g;
      master_clear_n <= m;
   endtask : drive
endmodule : wswc_core_model

// ===== sim/tb.sv
// Self-checking bench for the watchdog, flags and sleep control block.
// Assumes the core model file and the map header on the include path.
`timescale 1ns/1ps
`include "wswc_map.svh"
// Notes an expected and an observed value for the watching process.
`define NOTE(e, g) begin q_exp.push_back(32'(e)); q_got.push_back(32'(g)); end
module tb;
   localparam int unsigned TICKS = 8;  // Short count keeps the run brief.
   localparam logic [31:0] A_ST = `WSWC_IDX_STATUS * 4;
   localparam logic [31:0] A_OP = `WSWC_IDX_OPTION * 4;
   localparam logic [31:0] A_CF = `WSWC_IDX_CONFIG * 4;
   logic        sys_clk, rst, hsel, hwrite, hreadyout, sleep_instr, kick_watchdog_instr;
   logic [31:0] haddr, hwdata, hrdata, rd, e_v, g_v, lfsr_q;
   logic [1:0]  htrans;
   logic [2:0]  hsize, wake_irq_flags, wake_irq_enables;
   logic [7:0]  config_word_in;
   logic        timer_irq_flag, timer_irq_enable, global_irq_enable, master_clear_n, g;
   logic        internal_reset, main_osc_en, io_hold, prefetch_next, sleep_nop, hresp;
   logic        wake_pulse, vector_branch, timeout_flag_n, powerdown_flag_n;
   logic [31:0] q_exp[$];  // Expected values in order of noting.
   logic [31:0] q_got[$];  // Observed values in the same order.
   int          n_fail, n_tests, n, n0, i;
   wswc_top #(.WDT_TICKS(TICKS), .WDT_W(15), .TICK_CYC(2)) wswc_top_inst (
      .sys_clk(sys_clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .config_word_in(config_word_in),
      .master_clear_n(master_clear_n), .sleep_instr(sleep_instr),
      .kick_watchdog_instr(kick_watchdog_instr), .wake_irq_flags(wake_irq_flags),
      .wake_irq_enables(wake_irq_enables), .timer_irq_flag(timer_irq_flag),
      .timer_irq_enable(timer_irq_enable), .global_irq_enable(global_irq_enable),
      .internal_reset(internal_reset), .main_osc_en(main_osc_en), .io_hold(io_hold),
      .prefetch_next(prefetch_next), .sleep_nop(sleep_nop), .wake_pulse(wake_pulse),
      .vector_branch(vector_branch), .timeout_flag_n(timeout_flag_n),
      .powerdown_flag_n(powerdown_flag_n));
   wswc_core_model core_inst (
      .sys_clk(sys_clk), .sleep_instr(sleep_instr), .kick_watchdog_instr(kick_watchdog_instr),
      .wake_irq_flags(wake_irq_flags), .wake_irq_enables(wake_irq_enables),
      .timer_irq_flag(timer_irq_flag), .timer_irq_enable(timer_irq_enable),
      .global_irq_enable(global_irq_enable), .master_clear_n(master_clear_n));
   // ****
   // Clock, checking and closing.
   // ****
   always #20 sys_clk = ~sys_clk;
   // The watcher takes the oldest note whenever one waits; case equality traps unknowns.
   always @(negedge sys_clk) begin
      while (q_exp.size() > 0) begin
         e_v = q_exp.pop_front();
         g_v = q_got.pop_front();
         n_tests++;
         if (e_v !== g_v) begin
            n_fail++;
            $display("BAD t=%0t exp=%h got=%h", $time, e_v, g_v);
         end
      end
   end
   task automatic print_verdict();
      $display("tests=%0d mismatches=%0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : print_verdict
   function automatic logic [31:0] lfsr_next(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction : lfsr_next
   // Waits for reset (0), wake (1) or ready (2); a spent bound ends the run.
   task automatic wait_hi(input int sel, output int k);
      for (k = 0; k < 1000; k++) begin
         @(posedge sys_clk);
         if ((sel == 0 && internal_reset === 1'b1) || (sel == 1 && wake_pulse === 1'b1) ||
             (sel == 2 && hreadyout === 1'b1)) return;
      end
      n_fail++;
      print_verdict();
   endtask : wait_hi
   // One single AHB transfer; read data is taken at the edge closing the data phase.
   task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      {hsel, htrans, haddr, hwrite} <= {1'b1, 2'b10, a, wr};
      wait_hi(2, n);
      htrans <= 2'b00;
      hwdata <= d;
      wait_hi(2, n);
      rd = hrdata;
   endtask : bus
   task automatic do_reset(input logic [7:0] fuse);
      config_word_in <= fuse;
      rst <= 1'b1;
      repeat (3) @(posedge sys_clk);
      rst <= 1'b0;
      @(posedge sys_clk);
   endtask : do_reset
   // Clears the count under a new option value and times the expiry.
   task automatic time_expiry(input logic [7:0] opt, output int k);
      bus(1'b1, A_OP, {24'h0, opt});
      core_inst.kick();
      wait_hi(0, k);
   endtask : time_expiry
   // ****
   // Main sequence.
   // ****
   initial begin
      {sys_clk, rst, hsel, hwrite, htrans, haddr, hwdata} = {4'b0100, 2'b00, 64'h0};
      {hsize, config_word_in, lfsr_q, n_fail, n_tests} = {3'b010, 8'h00, 32'd72929, 64'd0};
      do_reset(8'h00);
      bus(1'b1, A_OP, 32'h0);
      n = 0;
      repeat (300) @(posedge sys_clk) if (internal_reset !== 1'b0) n++;
      `NOTE(0, n)
      $display("done fuse off");
      do_reset(8'h04);
      bus(1'b0, A_OP, 32'h0); `NOTE(8'hff, rd)
      bus(1'b0, A_ST, 32'h0); `NOTE(8'h18, rd)
      bus(1'b1, A_CF, 32'h0); bus(1'b0, A_CF, 32'h0); `NOTE(8'h04, rd)
      bus(1'b0, 32'h100, 32'h0); `NOTE(0, rd | 32'(hresp))
      lfsr_q = lfsr_next(lfsr_q);
      bus(1'b1, A_OP, {24'h0, lfsr_q[7:0]}); bus(1'b0, A_OP, 32'h0); `NOTE(lfsr_q[7:0], rd)
      $display("done registers");
      // Plain count, then a 1:4 prescaler; the tick phase allows a little slack.
      time_expiry(8'h00, n0);
      `NOTE(1, n0 >= 2 * TICKS - 2 && n0 <= 2 * TICKS + 4)
      `NOTE(2'b01, {timeout_flag_n, powerdown_flag_n})
      time_expiry(8'h0a, n);
      `NOTE(1, n >= 8 * TICKS - 2 && n <= 8 * TICKS + 8)
      bus(1'b1, A_OP, 32'h0);
      n = 0;
      repeat (20) begin
         core_inst.kick();
         repeat (8) @(posedge sys_clk) if (internal_reset !== 1'b0) n++;
      end
      `NOTE(0, n)
      $display("done watchdog run");
      core_inst.do_sleep();
      @(negedge sys_clk);
      `NOTE(5'b10011, {io_hold, main_osc_en, powerdown_flag_n, timeout_flag_n, prefetch_next})
      core_inst.drive(3'h0, 3'h0, 2'b11, 1'b1, 1'b1);
      wait_hi(1, n);
      // A wake from the pending timer would come at once, not after a full count.
      `NOTE(1, n > 8)
      `NOTE(5'b00000, {internal_reset, timeout_flag_n, powerdown_flag_n, vector_branch, io_hold})
      core_inst.drive(3'h0, 3'h0, 2'b00, 1'b0, 1'b1);
      $display("done watchdog wake");
      // Each wake source in turn; the global enable is random and only steers the vector.
      for (i = 0; i < 3; i++) begin
         lfsr_q = lfsr_next(lfsr_q);
         g = lfsr_q[0];
         core_inst.drive(3'h0, 3'(1 << i), 2'b00, g, 1'b1);
         core_inst.do_sleep();
         core_inst.drive(3'(1 << i), 3'(1 << i), 2'b00, g, 1'b1);
         wait_hi(1, n);
         `NOTE({g, 3'b100}, {vector_branch, timeout_flag_n, powerdown_flag_n, internal_reset})
         core_inst.drive(3'h0, 3'h0, 2'b00, 1'b0, 1'b1);
      end
      // A pending wake source, then a pending timer, each turns sleep into a no-op.
      for (i = 0; i < 2; i++) begin
         core_inst.drive(3'(i == 0), 3'(i == 0), 2'(i == 1 ? 3 : 0), 1'b0, 1'b1);
         core_inst.do_sleep();
         @(negedge sys_clk);
         `NOTE(3'b101, {sleep_nop, io_hold, main_osc_en})
         core_inst.drive(3'h0, 3'h0, 2'b00, 1'b0, 1'b1);
      end
      $display("done interrupt wake");
      core_inst.do_sleep();
      core_inst.drive(3'h0, 3'h0, 2'b00, 1'b0, 1'b0);
      @(negedge sys_clk);
      `NOTE(2'b10, {internal_reset, wake_pulse})
      core_inst.drive(3'h0, 3'h0, 2'b00, 1'b0, 1'b1);
      repeat (2) @(posedge sys_clk);
      `NOTE(2'b10, {main_osc_en, io_hold})
      $display("done master clear");
      repeat (3) @(posedge sys_clk);
      print_verdict();
   end
endmodule : tb
